// ==== rtl/ocm_pkg.sv ====
// constants shared by the output compare time-base block
package ocm_pkg;
   localparam int OCM_CHANNELS = 3;
   localparam int OCM_CNT_W = 16;
   localparam int OCM_TICK_SRCS = 6;
   localparam int OCM_SYNC_SRCS = 21;
   // register index inside a channel window; channel n sits at n * OCM_CH_STRIDE
   localparam logic [7:0] OCM_CH_STRIDE = 8'h08;
   localparam logic [2:0] OCM_IDX_CTRL1 = 3'h0;
   localparam logic [2:0] OCM_IDX_CTRL2 = 3'h1;
   localparam logic [2:0] OCM_IDX_PRI = 3'h2;
   localparam logic [2:0] OCM_IDX_SEC = 3'h3;
   localparam logic [2:0] OCM_IDX_CNT = 3'h4;
   // compare_control_one fields
   localparam int OCM_MODE_LSB = 0;
   localparam int OCM_CLKSEL_LSB = 10;
   // compare_control_two fields
   localparam int OCM_SYNCSEL_LSB = 0;
   localparam int OCM_TRIGGER_RUN_STATUS_BIT = 6;
   localparam int OCM_TRIGMODE_BIT = 7;
   localparam int OCM_CASCADE_BIT = 8;
   localparam logic [4:0] OCM_SYNC_FREE = 5'h00;
   localparam logic [4:0] OCM_SYNC_SELF = 5'h1f;
   localparam logic [15:0] OCM_CTRL1_MASK = 16'h1c07;
   localparam logic [15:0] OCM_CTRL2_MASK = 16'h01df;
   localparam logic [15:0] OCM_CTRL_RESET = 16'h0000;
   localparam logic [15:0] OCM_CNT_RESET = 16'h0000;
   localparam logic [15:0] OCM_CNT_TOP = 16'hffff;
   localparam logic [15:0] OCM_CMP_RESET = 16'h0000;
   typedef enum logic [2:0] {
      OCM_OUT_OFF = 3'b000,
      OCM_OUT_SINGLE = 3'b001,
      OCM_OUT_CONT = 3'b010,
      OCM_OUT_PWM = 3'b011
   } ocm_out_mode_type;
endpackage : ocm_pkg

// ==== rtl/ocm_top.sv ====
// output compare time base: three channels, free/sync/trigger modes, 32-bit cascade
// Notes on behaviour
// - free-running counter counts up each selected tick, wrapping ffff to 0000.
// - a match of counter with primary or secondary value raises an event.
// - synchronous mode starts counting as soon as its clock source ticks.
// - synchronous mode clears the counter on every selected sync event.
// - trigger mode holds the counter until the selected source fires.
// - sync select zero, and reset, give free-running operation.
// - nonzero select: trigger mode bit one means trigger, zero means synchronous.
// - sync or trigger event comes from the source named by sync select.
// - twenty-one selectable external sync or trigger sources are offered.
// - three independent output compare channels.
// - each channel has a primary and a secondary compare register.
// - single pulse, continuous pulse and PWM output waveforms are supported.
// - counter clock picked from six tick sources per channel.
// - by default each channel runs alone on its own counter and compares.
// - odd/even channel pair can combine into one 32-bit channel.
// - in a pair the odd channel holds low half, even channel high half.
// - each low-half wrap increments the high-half counter.
// - cascade only when cascade enable is set in both channels of the pair.
// - trigger run status set on trigger; in trigger mode the counter is held zero while it is clear.
// - sync select 1f uses the channel's own secondary match as sync source.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ocm_top
   import ocm_pkg::*;
#(
   parameter int CHANNELS = OCM_CHANNELS
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic [OCM_TICK_SRCS-1:0] tick_source,
   input wire logic [OCM_SYNC_SRCS-1:0] sync_event,
   output logic [CHANNELS-1:0] primary_match,
   output logic [CHANNELS-1:0] secondary_match,
   output logic [CHANNELS-1:0] compare_out,
   output logic [CHANNELS-1:0] trigger_run_status
);
   // tick sources are foreign levels: two flops, then a rising-edge detector
   logic [OCM_TICK_SRCS-1:0] tick_meta_reg;
   logic [OCM_TICK_SRCS-1:0] tick_sync_reg;
   logic [OCM_TICK_SRCS-1:0] tick_prev_reg;
   logic [OCM_TICK_SRCS-1:0] tick_pulse;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         tick_meta_reg <= '0;
         tick_sync_reg <= '0;
         tick_prev_reg <= '0;
      end else begin
         tick_meta_reg <= tick_source;
         tick_sync_reg <= tick_meta_reg;
         tick_prev_reg <= tick_sync_reg;
      end
   end

   assign tick_pulse = tick_sync_reg & ~tick_prev_reg;

   // per-channel views shared across the generate loop for cascading
   logic [CHANNELS-1:0][15:0] cnt_all;
   logic [CHANNELS-1:0][15:0] ctrl1_all;
   logic [CHANNELS-1:0][15:0] ctrl2_all;
   logic [CHANNELS-1:0][15:0] pri_all;
   logic [CHANNELS-1:0][15:0] sec_all;
   logic [CHANNELS-1:0] wrap_all;
   logic [CHANNELS-1:0] clear_all;
   logic [CHANNELS-1:0] tickd_all;
   logic [CHANNELS-1:0] eqp_all;
   logic [CHANNELS-1:0] eqs_all;
   logic cascade_on;

   // channel 0 is the odd (low) member, channel 1 the even (high) member
   assign cascade_on = (CHANNELS > 1) && ctrl2_all[0][OCM_CASCADE_BIT]
      && ctrl2_all[CHANNELS > 1 ? 1 : 0][OCM_CASCADE_BIT];

   genvar gi;
   generate
      for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
         logic [15:0] ctrl1_reg;
         logic [15:0] ctrl2_reg;
         logic [15:0] pri_reg;
         logic [15:0] sec_reg;
         logic [15:0] cnt_reg;
         logic trig_stat_reg;
         logic tick_d_reg;
         logic pm_reg;
         logic sm_reg;
         logic out_reg;
         logic done_reg;
         logic hit;
         logic linked;
         logic paired;
         logic [2:0] clksel;
         logic [4:0] syncsel;
         logic own_tick;
         logic tick_i;
         logic [31:0] src_vec;
         logic evt;
         logic trig_mode;
         logic sync_mode;
         logic run;
         logic own_clear;
         logic clear;
         logic eq_p;
         logic eq_s;
         logic tick_eff;
         logic pm_next;
         logic sm_next;

         assign hit = (reg_addr[7:3] == 5'(gi));
         assign linked = (gi == 1) && cascade_on;
         assign paired = (gi < 2) && cascade_on;
         assign clksel = ctrl1_reg[OCM_CLKSEL_LSB +: 3];
         assign syncsel = ctrl2_reg[OCM_SYNCSEL_LSB +: 5];

         // codes 6 and 7 select no clock; counter simply stops
         assign own_tick = (clksel < 3'(OCM_TICK_SRCS)) ? tick_pulse[clksel] : 1'b0;
         assign tick_i = linked ? wrap_all[0] : own_tick;

         // code n (1..21) picks sync_event[n-1]; 1f picks own secondary match
         assign src_vec = {sm_reg, 9'h000, sync_event, 1'b0};
         assign evt = src_vec[syncsel];

         assign trig_mode = (syncsel != OCM_SYNC_FREE) && ctrl2_reg[OCM_TRIGMODE_BIT];
         assign sync_mode = (syncsel != OCM_SYNC_FREE) && !ctrl2_reg[OCM_TRIGMODE_BIT];
         assign run = !trig_mode || trig_stat_reg;
         assign own_clear = !run || (sync_mode && evt);
         // the high half follows the low half's clear so both restart together
         assign clear = linked ? clear_all[0] : own_clear;

         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               ctrl1_reg <= OCM_CTRL_RESET;
               pri_reg <= OCM_CMP_RESET;
               sec_reg <= OCM_CMP_RESET;
            end else if (reg_wr && hit) begin
               if (reg_addr[2:0] == OCM_IDX_CTRL1) begin
                  ctrl1_reg <= reg_wdata & OCM_CTRL1_MASK;
               end
               if (reg_addr[2:0] == OCM_IDX_PRI) begin
                  pri_reg <= reg_wdata;
               end
               if (reg_addr[2:0] == OCM_IDX_SEC) begin
                  sec_reg <= reg_wdata;
               end
            end
         end

         // status bit lives apart; ctrl2_reg keeps it zero and reads splice it in
         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               ctrl2_reg <= OCM_CTRL_RESET;
            end else if (reg_wr && hit && reg_addr[2:0] == OCM_IDX_CTRL2) begin
               ctrl2_reg <= reg_wdata & OCM_CTRL2_MASK & ~(16'h0001 << OCM_TRIGGER_RUN_STATUS_BIT);
            end
         end

         // hardware set beats a software clear in the same cycle
         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               trig_stat_reg <= 1'b0;
            end else if (trig_mode && evt) begin
               trig_stat_reg <= 1'b1;
            end else if (reg_wr && hit && reg_addr[2:0] == OCM_IDX_CTRL2) begin
               trig_stat_reg <= reg_wdata[OCM_TRIGGER_RUN_STATUS_BIT];
            end
         end

         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               cnt_reg <= OCM_CNT_RESET;
               tick_d_reg <= 1'b0;
            end else begin
               tick_d_reg <= tick_i && !clear;
               if (clear) begin
                  cnt_reg <= OCM_CNT_RESET;
               end else if (tick_i) begin
                  cnt_reg <= cnt_reg + 16'h0001;
               end
            end
         end

         assign eq_p = (cnt_reg == pri_reg);
         assign eq_s = (cnt_reg == sec_reg);

         // in a pair both halves must match, timed by the low half's tick
         assign tick_eff = paired ? tickd_all[0] : tick_d_reg;
         assign pm_next = tick_eff && (paired ? (eqp_all[0] && eqp_all[1]) : eq_p);
         assign sm_next = tick_eff && (paired ? (eqs_all[0] && eqs_all[1]) : eq_s);

         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               pm_reg <= 1'b0;
               sm_reg <= 1'b0;
            end else begin
               pm_reg <= pm_next;
               sm_reg <= sm_next;
            end
         end

         // waveform: single/continuous rise on primary, fall on secondary; pwm falls on primary, rises when a tick wraps the counter to 0000
         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               out_reg <= 1'b0;
               done_reg <= 1'b0;
            end else if (reg_wr && hit && reg_addr[2:0] == OCM_IDX_CTRL1) begin
               out_reg <= 1'b0;
               done_reg <= 1'b0; // rewriting control one re-arms a single pulse
            end else begin
               unique case (ctrl1_reg[OCM_MODE_LSB +: 3])
                  OCM_OUT_SINGLE: begin
                     if (pm_next && !done_reg) begin
                        out_reg <= 1'b1;
                     end else if (sm_next && out_reg) begin
                        out_reg <= 1'b0;
                        done_reg <= 1'b1;
                     end
                  end
                  OCM_OUT_CONT: begin
                     if (pm_next) begin
                        out_reg <= 1'b1;
                     end else if (sm_next) begin
                        out_reg <= 1'b0;
                     end
                  end
                  OCM_OUT_PWM: begin
                     if (pm_next) begin
                        out_reg <= 1'b0;
                     end else if (tick_eff && cnt_reg == OCM_CNT_RESET) begin
                        out_reg <= 1'b1;
                     end
                  end
                  default: begin
                     out_reg <= 1'b0;
                  end
               endcase
            end
         end

         assign cnt_all[gi] = cnt_reg;
         assign ctrl1_all[gi] = ctrl1_reg;
         assign ctrl2_all[gi] = ctrl2_reg | (16'(trig_stat_reg) << OCM_TRIGGER_RUN_STATUS_BIT);
         assign pri_all[gi] = pri_reg;
         assign sec_all[gi] = sec_reg;
         assign wrap_all[gi] = tick_i && !clear && (cnt_reg == OCM_CNT_TOP);
         assign clear_all[gi] = clear;
         assign tickd_all[gi] = tick_d_reg;
         assign eqp_all[gi] = eq_p;
         assign eqs_all[gi] = eq_s;
         assign primary_match[gi] = pm_reg;
         assign secondary_match[gi] = sm_reg;
         assign compare_out[gi] = out_reg;
         assign trigger_run_status[gi] = trig_stat_reg;
      end
   endgenerate

   // read data valid the cycle after the strobe only; unmapped reads give zero
   logic [4:0] rd_ch;
   logic [15:0] rd_next;

   assign rd_ch = reg_addr[7:3];

   always_comb begin
      rd_next = 16'h0000;
      if (reg_rd && rd_ch < 5'(CHANNELS)) begin
         unique case (reg_addr[2:0])
            OCM_IDX_CTRL1: rd_next = ctrl1_all[rd_ch];
            OCM_IDX_CTRL2: rd_next = ctrl2_all[rd_ch];
            OCM_IDX_PRI: rd_next = pri_all[rd_ch];
            OCM_IDX_SEC: rd_next = sec_all[rd_ch];
            OCM_IDX_CNT: rd_next = cnt_all[rd_ch];
            default: rd_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= rd_next;
      end
   end
endmodule : ocm_top
`default_nettype wire

// ==== tb/ocm_far_model.sv ====
// tick and sync sources standing outside the compare block
`timescale 1ns/1ps
`default_nettype none
module ocm_far_model (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [5:0] run,
   input wire logic [4:0] sync_code,
   output logic [5:0] tick_source,
   output logic [20:0] sync_event
);
   // a stopped source falls low so no stray edge is seen later
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) tick_source <= 6'h00;
      else tick_source <= run & ~tick_source;
   end
   // one-clock event pulse; codes above 21 name no source
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) sync_event <= 21'h000000;
      else if (sync_code != 5'h00 && sync_code <= 5'h15) sync_event <= 21'h1 << (sync_code - 5'h01);
      else sync_event <= 21'h000000;
   end
endmodule : ocm_far_model
`default_nettype wire

// ==== tb/ocm_top_monitor.sv ====
// port-level checker of the compare time base
`timescale 1ns/1ps
`default_nettype none
module ocm_top_monitor
   import ocm_pkg::*;
#(
   parameter int CHANNELS = OCM_CHANNELS
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic [OCM_TICK_SRCS-1:0] tick_source,
   input wire logic [OCM_SYNC_SRCS-1:0] sync_event,
   input wire logic [CHANNELS-1:0] primary_match,
   input wire logic [CHANNELS-1:0] secondary_match,
   input wire logic [CHANNELS-1:0] compare_out,
   input wire logic [CHANNELS-1:0] trigger_run_status
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   a_pri_one_cycle: assert property (primary_match != 0 |=> (primary_match & $past(primary_match)) == 0) else $error("primary match longer than one cycle");
   a_sec_one_cycle: assert property (secondary_match != 0 |=> (secondary_match & $past(secondary_match)) == 0) else $error("secondary match longer than one cycle");
   a_reset_quiet: assert property (disable iff (1'b0) !reset_n |-> (primary_match | secondary_match | compare_out | trigger_run_status) == 0) else $error("outputs active in reset");
   a_status_holds: assert property (!reg_wr |=> (trigger_run_status & $past(trigger_run_status)) == $past(trigger_run_status)) else $error("run status dropped without a write");
   a_status_cause: assert property ((trigger_run_status & ~$past(trigger_run_status)) != 0 |-> $past(reg_wr || sync_event != 0 || secondary_match != 0)) else $error("run status set without cause");
   a_no_tick_quiet: assert property ($stable(tick_source) [*8] |-> (primary_match | secondary_match) == 0) else $error("match without a tick");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data outside its cycle");
   a_unmapped_zero: assert property (reg_rd && (reg_addr[7:3] > 5'h02 || reg_addr[2:0] > 3'h4) |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
   c_pri_match: cover property (primary_match != 0);
   c_sec_match: cover property (secondary_match != 0);
   c_trig_run: cover property ($rose(trigger_run_status[2]));
endmodule : ocm_top_monitor
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench of the compare time base
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ocm_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic [5:0] tick_source;
   logic [20:0] sync_event;
   logic [2:0] primary_match, secondary_match, compare_out, trigger_run_status;
   logic [5:0] run = 6'h00;
   logic [4:0] sync_code = 5'h00;
   logic rd_seen = 1'b0;
   logic [15:0] rd_q[$];
   logic [15:0] n;
   int err_total = 0;
   int n_tests = 0;
   int pm_cnt = 0;
   int sm_cnt = 0;
   int out_rise = 0;
   logic out_prev = 1'b0;
   int cyc = 0;
   int seed = 32'h40bf;
   always #10 clk_sys = ~clk_sys;
   ocm_top u_ocm_top (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tick_source(tick_source), .sync_event(sync_event), .primary_match(primary_match),
      .secondary_match(secondary_match), .compare_out(compare_out),
      .trigger_run_status(trigger_run_status));
   ocm_far_model u_ocm_far_model (.clk_sys(clk_sys), .reset_n(reset_n), .run(run),
      .sync_code(sync_code), .tick_source(tick_source), .sync_event(sync_event));
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_val
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      rd_q.push_back(exp);
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask : rd
   // equal high and low phases, so 2k cycles give exactly k rising edges
   task automatic ticks(input logic [5:0] m, input logic [15:0] k);
      @(posedge clk_sys);
      run <= m;
      repeat (2 * k) @(posedge clk_sys);
      run <= 6'h00;
      repeat (8) @(posedge clk_sys);
   endtask : ticks
   task automatic sync(input logic [4:0] c);
      @(posedge clk_sys);
      sync_code <= c;
      @(posedge clk_sys);
      sync_code <= 5'h00;
      repeat (4) @(posedge clk_sys);
   endtask : sync
   always @(posedge clk_sys) rd_seen <= reg_rd;
   always @(negedge clk_sys) if (rd_seen === 1'b1) check_val(reg_rdata, rd_q.pop_front());
   always @(posedge clk_sys) if (primary_match[0] === 1'b1) pm_cnt++;
   always @(posedge clk_sys) if (secondary_match[0] === 1'b1) sm_cnt++;
   // count rises of the channel 0 waveform so a stuck output is caught
   always @(posedge clk_sys) begin
      out_prev <= compare_out[0];
      if (compare_out[0] === 1'b1 && out_prev === 1'b0) out_rise++;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         $display("mismatch at %0t: run did not finish", $time);
         give_verdict();
      end
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      for (int ch = 0; ch < 3; ch++) begin
         rd(8'(ch * 8 + 1), 16'h0000);
         rd(8'(ch * 8 + 4), 16'h0000);
      end
      rd(8'h05, 16'h0000);
      rd(8'h18, 16'h0000);
      wr(8'h04, 16'h1234);
      rd(8'h04, 16'h0000);
      wr(8'h01, 16'hffff);
      rd(8'h01, 16'h01df);
      wr(8'h01, 16'h0000);
      $display("test registers done");
      n = 16'h0003 + 16'($random(seed) & 7);
      wr(8'h02, n - 16'h0001);
      wr(8'h03, n);
      rd(8'h02, n - 16'h0001);
      wr(8'h00, 16'h0002);
      ticks(6'h01, n);
      rd(8'h04, n);
      check_val(16'(pm_cnt), 16'h0001);
      check_val(16'(sm_cnt), 16'h0001);
      check_val(16'(out_rise), 16'h0001);
      check_val(16'(compare_out[0]), 16'h0000);
      $display("test free run done");
      wr(8'h08, 16'h0400);
      wr(8'h09, 16'h0002);
      sync(5'h02);
      ticks(6'h02, 16'h0005);
      rd(8'h0c, 16'h0005);
      sync(5'h02);
      rd(8'h0c, 16'h0000);
      $display("test sync done");
      wr(8'h09, 16'h0100);
      ticks(6'h02, 16'h0003);
      rd(8'h0c, 16'h0003);
      wr(8'h01, 16'h0100);
      ticks(6'h02, 16'h0003);
      rd(8'h0c, 16'h0003);
      rd(8'h04, n);
      wr(8'h01, 16'h0000);
      wr(8'h09, 16'h0000);
      $display("test cascade done");
      wr(8'h10, 16'h0800);
      wr(8'h11, 16'h0083);
      ticks(6'h04, 16'h0004);
      rd(8'h14, 16'h0000);
      check_val(16'(trigger_run_status[2]), 16'h0000);
      sync(5'h03);
      check_val(16'(trigger_run_status[2]), 16'h0001);
      rd(8'h11, 16'h00c3);
      ticks(6'h04, 16'h0005);
      rd(8'h14, 16'h0005);
      wr(8'h11, 16'h0083);
      rd(8'h14, 16'h0000);
      $display("test trigger done");
      repeat (2) @(posedge clk_sys);
      give_verdict();
   end
endmodule : tb
bind ocm_top ocm_top_monitor #(.CHANNELS(CHANNELS)) u_ocm_top_monitor (.clk_sys(clk_sys),
   .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tick_source(tick_source), .sync_event(sync_event),
   .primary_match(primary_match), .secondary_match(secondary_match),
   .compare_out(compare_out), .trigger_run_status(trigger_run_status));
`default_nettype wire
